//--- rtl/bus_controller.sv
// Device end: external bus controller with ready and hold arbitration.
// Assumes Avalon-MM master on mclk_in and the far end on ext_bus_if.
`include "ebc_consts.svh"

// Functional notes
// - Ready high adds wait, low ends cycle
// - Programmed wait states precede ready sampling
// - Read/write delay postpones command leading edge
// - Far end may drop ready after command
// - Async ready held low long enough
// - Mux wait, optional tristate wait after cycle
// - Next cycle only after trailing waits
// - Finish running cycle before granting hold
// - Hold sampled, outputs change on bus clock
// - Release floats chip selects and other signals
// - Regain request only after grant completes
// - Regain starts only on hold rising
// - Master may release hold unrequested
// - Own cycle may start after regain
// - Read data latched at command rise
module bus_controller (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Avalon-MM slave
   input wire logic [2:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // External bus pins
   ext_bus_if.dev bus
);

   ebc_pkg::bus_state_type state_q;
   logic [3:0] div_q;
   logic bclk_q;
   logic tick;
   logic ready_s;
   logic hold_s;
   logic hold_prev_q;
   logic [6:0] ctrl_q;
   logic [15:0] addr_reg_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic cmd_write_q;
   logic pending_q;
   logic done_q;
   logic rd_ack_q;
   logic [31:0] readdata_q;
   logic [3:0] wait_cnt_q;
   logic cmd_wr_acc;
   logic start_cycle;
   logic cycle_end;
   logic [15:0] bus_addr_q;
   logic ale_q;
   logic rd_n_q;
   logic wr_n_q;
   logic cs_n_q;
   logic drive_q;
   logic bus_grant_acknowledge_out_n_q;
   logic regain_bus_request_out_n_q;
   logic grant_done_q;

   // ==========================================================
   // Bus clock by divider; tick marks each rising bus clock edge
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         div_q <= 4'h0;
         bclk_q <= 1'b0;
      end else if (div_q == `EBC_BCLK_HALF - 4'h1) begin
         div_q <= 4'h0;
         bclk_q <= ~bclk_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end
   assign tick = (div_q == `EBC_BCLK_HALF - 4'h1) && !bclk_q;

   // ==========================================================
   // Ready and hold arrive from outside the clock domain
   sync3 #(.WIDTH(2), .INIT(2'h3)) u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .async_in({bus.ready_n, bus.hold_n}),
      .sync_out({ready_s, hold_s})
   );

   // ==========================================================
   // Register slave; a new command stalls while one is pending
   assign cmd_wr_acc = avs_write_in && avs_address_in == `EBC_REG_CMD;
   assign avs_waitrequest_out = (avs_read_in && !rd_ack_q) ||
                                (cmd_wr_acc && pending_q);
   assign avs_readdata_out = readdata_q;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= `EBC_CTRL_RESET;
         addr_reg_q <= 16'h0000;
         wdata_q <= 16'h0000;
         cmd_write_q <= 1'b0;
      end else if (avs_write_in && !avs_waitrequest_out) begin
         case (avs_address_in)
            `EBC_REG_CTRL: ctrl_q <= avs_writedata_in[6:0];
            `EBC_REG_ADDR: addr_reg_q <= avs_writedata_in[15:0];
            `EBC_REG_WDATA: wdata_q <= avs_writedata_in[15:0];
            `EBC_REG_CMD: cmd_write_q <= avs_writedata_in[`EBC_CMD_WRITE];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // Reads take two cycles so read data come from a flip-flop
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rd_ack_q <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end else begin
         rd_ack_q <= avs_read_in && !rd_ack_q;
         if (avs_read_in && !rd_ack_q) begin
            case (avs_address_in)
               `EBC_REG_CTRL: readdata_q <= {25'h0, ctrl_q};
               `EBC_REG_ADDR: readdata_q <= {16'h0, addr_reg_q};
               `EBC_REG_WDATA: readdata_q <= {16'h0, wdata_q};
               `EBC_REG_CMD: readdata_q <= {31'h0, cmd_write_q};
               `EBC_REG_STATUS: readdata_q <= {28'h0, done_q,
                  !bus_grant_acknowledge_out_n_q, state_q != ebc_pkg::st_idle, pending_q};
               `EBC_REG_RDATA: readdata_q <= {16'h0, rdata_q};
               default: readdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Pending flag: set wins over the clear by cycle start
   assign start_cycle = tick && state_q == ebc_pkg::st_idle &&
                        hold_s && pending_q;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         pending_q <= 1'b0;
      end else if (cmd_wr_acc && !avs_waitrequest_out) begin
         pending_q <= 1'b1;
      end else if (start_cycle) begin
         pending_q <= 1'b0;
      end
   end

   // Done flag: cleared by a new command, set at cycle end
   assign cycle_end = tick && state_q == ebc_pkg::st_cmd &&
                      wait_cnt_q == 4'h0 && !ready_s;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         done_q <= 1'b0;
      end else if (cycle_end) begin
         done_q <= 1'b1;
      end else if (cmd_wr_acc && !avs_waitrequest_out) begin
         done_q <= 1'b0;
      end
   end

   // ==========================================================
   // Cycle and arbitration sequencer, stepped on bus clock rise
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_q <= ebc_pkg::st_idle;
         wait_cnt_q <= 4'h0;
      end else if (tick) begin
         case (state_q)
            ebc_pkg::st_idle: begin
               if (!hold_s) begin
                  state_q <= ebc_pkg::st_granted;
               end else if (pending_q) begin
                  state_q <= ebc_pkg::st_addr;
               end
            end
            ebc_pkg::st_addr: begin
               wait_cnt_q <= ctrl_q[`EBC_CTRL_MCW_MSB:`EBC_CTRL_MCW_LSB];
               state_q <= ctrl_q[`EBC_CTRL_RWDLY] ? ebc_pkg::st_delay :
                          ebc_pkg::st_cmd;
            end
            ebc_pkg::st_delay: state_q <= ebc_pkg::st_cmd;
            ebc_pkg::st_cmd: begin
               if (wait_cnt_q != 4'h0) begin
                  wait_cnt_q <= wait_cnt_q - 4'h1;
               end else if (!ready_s) begin
                  // Ready high keeps this state: one wait per tick
                  if (ctrl_q[`EBC_CTRL_MUX]) begin
                     state_q <= ebc_pkg::st_mux;
                  end else if (ctrl_q[`EBC_CTRL_TRI]) begin
                     state_q <= ebc_pkg::st_tri;
                  end else begin
                     state_q <= ebc_pkg::st_idle;
                  end
               end
            end
            ebc_pkg::st_mux: begin
               state_q <= ctrl_q[`EBC_CTRL_TRI] ? ebc_pkg::st_tri :
                          ebc_pkg::st_idle;
            end
            ebc_pkg::st_tri: state_q <= ebc_pkg::st_idle;
            ebc_pkg::st_granted: begin
               // Only the rising hold edge ends the grant
               if (hold_s && !hold_prev_q) begin
                  state_q <= ebc_pkg::st_regain;
               end
            end
            ebc_pkg::st_regain: state_q <= ebc_pkg::st_idle;
            default: state_q <= ebc_pkg::st_idle;
         endcase
      end
   end

   // Hold level seen at the previous bus clock edge
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         hold_prev_q <= 1'b1;
      end else if (tick) begin
         hold_prev_q <= hold_s;
      end
   end

   // ==========================================================
   // Pin drivers, all changed just after a bus clock edge
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         bus_addr_q <= 16'h0000;
         ale_q <= 1'b0;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         cs_n_q <= 1'b1;
         rdata_q <= 16'h0000;
      end else if (tick) begin
         ale_q <= start_cycle;
         if (start_cycle) begin
            bus_addr_q <= addr_reg_q;
            cs_n_q <= 1'b0;
         end
         // Command leading edge after address, or one later with delay
         if ((state_q == ebc_pkg::st_addr && !ctrl_q[`EBC_CTRL_RWDLY]) ||
             state_q == ebc_pkg::st_delay) begin
            rd_n_q <= cmd_write_q;
            wr_n_q <= !cmd_write_q;
         end
         if (cycle_end) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            if (!cmd_write_q) begin
               rdata_q <= bus.ext_data;
            end
         end
      end
   end

   // ==========================================================
   // Grant handshake; request back only after grant completes
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         drive_q <= 1'b1;
         bus_grant_acknowledge_out_n_q <= 1'b1;
         regain_bus_request_out_n_q <= 1'b1;
         grant_done_q <= 1'b0;
      end else if (tick) begin
         if (state_q == ebc_pkg::st_idle && !hold_s) begin
            drive_q <= 1'b0;
            bus_grant_acknowledge_out_n_q <= 1'b0;
         end
         grant_done_q <= state_q == ebc_pkg::st_granted;
         regain_bus_request_out_n_q <= !(state_q == ebc_pkg::st_granted && grant_done_q &&
                       pending_q);
         if (state_q == ebc_pkg::st_granted && hold_s && !hold_prev_q) begin
            bus_grant_acknowledge_out_n_q <= 1'b1;
            regain_bus_request_out_n_q <= 1'b1;
         end
         if (state_q == ebc_pkg::st_regain) begin
            drive_q <= 1'b1;
         end
      end
   end

   // Pin assignments; released signals float, chip select pulled high
   assign bus.bus_clock_output = bclk_q;
   assign bus.addr = bus_addr_q;
   assign bus.addr_oe = drive_q;
   assign bus.ale = ale_q;
   assign bus.rd_n = rd_n_q;
   assign bus.wr_n = wr_n_q;
   assign bus.cmd_oe = drive_q;
   assign bus.chip_select_outputs_n = cs_n_q;
   assign bus.cs_oe = drive_q;
   assign bus.dev_data = wdata_q;
   assign bus.dev_data_oe = drive_q && !wr_n_q;
   assign bus.bus_grant_acknowledge_n = bus_grant_acknowledge_out_n_q;
   assign bus.regain_bus_request_n = regain_bus_request_out_n_q;

endmodule : bus_controller

//--- rtl/ebc_consts.svh
// Constants of the external bus controller and its far end.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH

// ==========================================================
// Bus clock divider (mclk cycles per bus clock half period)
`define EBC_BCLK_HALF 4'h4

// ==========================================================
// Register word indices on the Avalon-MM slave
`define EBC_REG_CTRL 3'h0
`define EBC_REG_ADDR 3'h1
`define EBC_REG_WDATA 3'h2
`define EBC_REG_CMD 3'h3
`define EBC_REG_STATUS 3'h4
`define EBC_REG_RDATA 3'h5

// ==========================================================
// Control register fields
`define EBC_CTRL_MCW_LSB 0
`define EBC_CTRL_MCW_MSB 3
`define EBC_CTRL_RWDLY 4
`define EBC_CTRL_MUX 5
`define EBC_CTRL_TRI 6
`define EBC_CTRL_RESET 7'h00

// ==========================================================
// Command and status fields
`define EBC_CMD_WRITE 0
`define EBC_STAT_PENDING 0
`define EBC_STAT_BUSY 1
`define EBC_STAT_GRANTED 2
`define EBC_STAT_DONE 3

// ==========================================================
// Far end: memory depth index width
`define EBC_MEM_AW 4

`endif

//--- rtl/ebc_pkg.sv
// Types used by the bus controller; its far end uses none.
// Assumes ebc_consts.svh for numeric constants.
package ebc_pkg;

   // ==========================================================
   // Bus controller cycle states
   typedef enum logic [3:0] {
      st_idle = 4'h0,
      st_addr = 4'h1,
      st_delay = 4'h2,
      st_cmd = 4'h3,
      st_mux = 4'h4,
      st_tri = 4'h5,
      st_granted = 4'h6,
      st_regain = 4'h7
   } bus_state_type;

endpackage : ebc_pkg

//--- rtl/ext_bus_if.sv
// Pins between the bus controller and the external party.
// Assumes the bench resolves two-way and pulled wires from enables.
interface ext_bus_if;

   // ==========================================================
   // Driven by the controller
   logic bus_clock_output;
   logic [15:0] addr;
   logic addr_oe;
   logic ale;
   logic rd_n;
   logic wr_n;
   logic cmd_oe;
   logic chip_select_outputs_n;
   logic cs_oe;
   logic [15:0] dev_data;
   logic dev_data_oe;
   logic bus_grant_acknowledge_n;
   logic regain_bus_request_n;

   // ==========================================================
   // Driven by the external party
   logic [15:0] ext_data;
   logic ext_data_oe;
   logic ready_n;
   logic hold_n;

   modport dev (
      output bus_clock_output, addr, addr_oe, ale, rd_n, wr_n, cmd_oe,
      output chip_select_outputs_n, cs_oe, dev_data, dev_data_oe,
      output bus_grant_acknowledge_n, regain_bus_request_n,
      input ext_data, ext_data_oe, ready_n, hold_n
   );

   modport ext (
      input bus_clock_output, addr, addr_oe, ale, rd_n, wr_n, cmd_oe,
      input chip_select_outputs_n, cs_oe, dev_data, dev_data_oe,
      input bus_grant_acknowledge_n, regain_bus_request_n,
      output ext_data, ext_data_oe, ready_n, hold_n
   );

endinterface : ext_bus_if

//--- rtl/sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes when stages 2 and 3 agree.
module sync3 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // ==========================================================
   // Stage chain; first stage feeds only the second
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a bit only once two stages agree, per bit
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : g_agree
      always_ff @(posedge mclk_in) begin
         if (!rst_n_in) begin
            sync_out[i] <= INIT[i];
         end else if (s2_q[i] == s3_q[i]) begin
            sync_out[i] <= s3_q[i];
         end
      end
   end

endmodule : sync3

//--- rtl/ext_party.sv
// Far end: memory with ready generation and an external bus master.
// Assumes pins from the controller are asynchronous to mclk_in.
`include "ebc_consts.svh"

module ext_party (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // User side
   input wire logic [3:0] ready_delay_in,
   input wire logic hold_request_in,
   output logic granted_out,
   output logic regain_wanted_out,
   // External bus pins
   ext_bus_if.ext bus
);

   logic bclk_s;
   logic rd_n_s;
   logic wr_n_s;
   logic bus_grant_acknowledge_out_n_s;
   logic regain_bus_request_out_n_s;
   logic bclk_prev_q;
   logic wr_prev_q;
   logic btick;
   logic [3:0] cnt_q;
   logic ready_n_q;
   logic hold_n_q;
   logic [15:0] rdo_q;
   logic [15:0] mem_q [0:(1<<`EBC_MEM_AW)-1];

   // ==========================================================
   // Command, grant, regain and bus clock pins pass the three-stage filter
   sync3 #(.WIDTH(5), .INIT(5'h1e)) u_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .async_in({bus.rd_n, bus.wr_n, bus.bus_grant_acknowledge_n,
                 bus.regain_bus_request_n, bus.bus_clock_output}),
      .sync_out({rd_n_s, wr_n_s, bus_grant_acknowledge_out_n_s, regain_bus_request_out_n_s, bclk_s})
   );

   assign btick = bclk_s && !bclk_prev_q;

   // ==========================================================
   // Ready after a delay; withdrawn on command trailing edge
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         bclk_prev_q <= 1'b0;
         wr_prev_q <= 1'b1;
         cnt_q <= 4'h0;
         ready_n_q <= 1'b1;
      end else begin
         bclk_prev_q <= bclk_s;
         wr_prev_q <= wr_n_s;
         if (rd_n_s && wr_n_s) begin
            cnt_q <= 4'h0;
            ready_n_q <= 1'b1;
         end else if (btick) begin
            if (cnt_q >= ready_delay_in) begin
               ready_n_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end

   // Memory: write captured at write rise, read data held registered
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rdo_q <= 16'h0000;
      end else begin
         if (wr_n_s && !wr_prev_q) begin
            mem_q[bus.addr[`EBC_MEM_AW-1:0]] <= bus.dev_data;
         end
         rdo_q <= mem_q[bus.addr[`EBC_MEM_AW-1:0]];
      end
   end

   // ==========================================================
   // Master: hold may drop at any time, changed at bus clock rise
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         hold_n_q <= 1'b1;
      end else if (btick) begin
         hold_n_q <= !hold_request_in;
      end
   end

   assign granted_out = !bus_grant_acknowledge_out_n_s;
   assign regain_wanted_out = !regain_bus_request_out_n_s;
   assign bus.ready_n = ready_n_q;
   assign bus.hold_n = hold_n_q;
   assign bus.ext_data = rdo_q;
   assign bus.ext_data_oe = !rd_n_s;

endmodule : ext_party

//--- verification/ext_bus_arb_sva.sv
// Checker for the pins between the bus controller and the far end.
// Assumes the pins arrive as plain inputs on the controller clock.
module ext_bus_arb_sva (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Bus pins
   input wire logic addr_oe,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic cmd_oe,
   input wire logic chip_select_outputs_n,
   input wire logic cs_oe,
   input wire logic bus_grant_acknowledge_n,
   input wire logic regain_bus_request_n,
   input wire logic ready_n,
   input wire logic hold_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Arbitration
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   property p_float;
      !bus_grant_acknowledge_n |-> !cs_oe && !addr_oe && !cmd_oe;
   endproperty
   a_float: assert property (p_float)
      else $error("bus driven while granted away");
   property p_grant_idle;
      $fell(bus_grant_acknowledge_n) |-> rd_n && wr_n && $past(rd_n && wr_n);
   endproperty
   a_grant_idle: assert property (p_grant_idle)
      else $error("grant given inside a running cycle");
   property p_req_late;
      $fell(bus_grant_acknowledge_n) |-> regain_bus_request_n [*8];
   endproperty
   a_req_late: assert property (p_req_late)
      else $error("regain request too early in grant");
   property p_req_in_grant;
      !regain_bus_request_n |-> !bus_grant_acknowledge_n;
   endproperty
   a_req_in_grant: assert property (p_req_in_grant)
      else $error("regain request outside grant");
   property p_regain_hold;
      $rose(bus_grant_acknowledge_n) |-> hold_n && $past(hold_n, 3);
   endproperty
   a_regain_hold: assert property (p_regain_hold)
      else $error("regain without hold release");
   property p_ack_steady;
      $changed(bus_grant_acknowledge_n) |=> $stable(bus_grant_acknowledge_n) [*7];
   endproperty
   a_ack_steady: assert property (p_ack_steady)
      else $error("grant ack changed between bus clock ticks");
   property p_regain_float;
      $rose(bus_grant_acknowledge_n) |-> !addr_oe [*7];
   endproperty
   a_regain_float: assert property (p_regain_float)
      else $error("bus driven before regain tick");
   // ==========================================================
   // Bus cycles
   property p_end_ready;
      $rose(rd_n) || $rose(wr_n) |-> !ready_n && !$past(ready_n, 3);
   endproperty
   a_end_ready: assert property (p_end_ready)
      else $error("command ended without ready low");
   property p_start_free;
      $rose(ale) |-> bus_grant_acknowledge_n && rd_n && wr_n;
   endproperty
   a_start_free: assert property (p_start_free)
      else $error("cycle started while busy or granted");
   property p_cmd_cs;
      $fell(rd_n) || $fell(wr_n) |-> !chip_select_outputs_n && cs_oe && !ale;
   endproperty
   a_cmd_cs: assert property (p_cmd_cs)
      else $error("command without chip select");
   // Main scenarios reached
   c_grant: cover property ($fell(bus_grant_acknowledge_n));
   c_regain_req: cover property ($fell(regain_bus_request_n));
   c_read_end: cover property ($rose(rd_n));
endmodule : ext_bus_arb_sva

//--- verification/ext_bus_ready_and_hold_arbitration_test.sv
// Testbench: controller and far end joined by the bus interface.
// Assumes the register map and timing of the designer's hand-over.
module ext_bus_ready_and_hold_arbitration_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================================
   // Signals
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] av_addr = 3'h0;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wdata = 32'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic [3:0] rdy_dly = 4'h0;
   logic hold_req = 1'b0;
   logic granted;
   logic regain_seen;
   logic ale_q = 1'b0;
   logic cmd_q = 1'b1;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   int t_ale = 0;
   int t_fall = 0;
   int t_rise = 0;
   int gap = 0;
   int asked = 0;
   ext_bus_if i_ext_bus_if ();
   wire cmd_high = i_ext_bus_if.rd_n & i_ext_bus_if.wr_n;
   // Pull-up on the chip select when released
   wire cs_level = i_ext_bus_if.cs_oe ? i_ext_bus_if.chip_select_outputs_n
      : 1'b1;
   // ==========================================================
   // Design and checker
   bus_controller i_bus_controller (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .avs_address_in(av_addr),
      .avs_read_in(av_rd), .avs_write_in(av_wr),
      .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
      .avs_waitrequest_out(av_wait), .bus(i_ext_bus_if));
   ext_party i_ext_party (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .ready_delay_in(rdy_dly), .hold_request_in(hold_req),
      .granted_out(granted), .regain_wanted_out(regain_seen),
      .bus(i_ext_bus_if));
   ext_bus_arb_sva i_ext_bus_arb_sva (.mclk_in(mclk_in),
      .rst_n_in(rst_n_in), .addr_oe(i_ext_bus_if.addr_oe),
      .ale(i_ext_bus_if.ale), .rd_n(i_ext_bus_if.rd_n),
      .wr_n(i_ext_bus_if.wr_n), .cmd_oe(i_ext_bus_if.cmd_oe),
      .chip_select_outputs_n(i_ext_bus_if.chip_select_outputs_n),
      .cs_oe(i_ext_bus_if.cs_oe),
      .bus_grant_acknowledge_n(i_ext_bus_if.bus_grant_acknowledge_n),
      .regain_bus_request_n(i_ext_bus_if.regain_bus_request_n),
      .ready_n(i_ext_bus_if.ready_n), .hold_n(i_ext_bus_if.hold_n));
   always #5 mclk_in = ~mclk_in;
   // Edge times of the bus cycle, in controller cycles
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      ale_q <= i_ext_bus_if.ale;
      cmd_q <= cmd_high;
      if (regain_seen === 1'b1) asked <= asked + 1;
      if (i_ext_bus_if.ale && !ale_q) begin
         t_ale <= cyc;
         gap <= cyc - t_rise;
      end
      if (!cmd_high && cmd_q) t_fall <= cyc;
      if (cmd_high && !cmd_q) t_rise <= cyc;
   end
   // ==========================================================
   // Tasks
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Avalon access; waitrequest and data taken at the rising edge
   task automatic av(input bit w, input logic [2:0] a,
      input logic [31:0] d, output logic [31:0] r);
      logic wq;
      int n;
      n = 0;
      @(posedge mclk_in);
      av_addr <= a;
      av_wdata <= d;
      av_rd <= !w;
      av_wr <= w;
      do begin
         @(posedge mclk_in);
         wq = av_wait;
         r = av_rdata;
         n++;
      end while (wq !== 1'b0 && n < 4000);
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      if (wq !== 1'b0) chk("waitrequest", 32'h0, {31'h0, wq});
   endtask : av
   // Poll status until done with nothing pending or busy
   task automatic idle();
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         av(1'b0, 3'h4, 32'h0, s);
         n++;
      end while (s[3:0] !== 4'h8 && n < 300);
      chk("status", 32'h8, {28'h0, s[3:0]});
   endtask : idle
   task automatic wt(input bit sel, input logic v);
      int n;
      n = 0;
      while ((sel ? regain_seen : granted) !== v && n < 3000) begin
         @(posedge mclk_in);
         n++;
      end
      chk(sel ? "regain" : "granted", {31'h0, v},
         {31'h0, sel ? regain_seen : granted});
   endtask : wt
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // ==========================================================
   // Tests
   initial begin
      logic [31:0] r;
      logic [7:0] c;
      int m;
      int n0;
      logic [7:0] ctab [4] = '{8'h40, 8'h13, 8'h62, 8'h35};
      logic [3:0] dtab [4] = '{4'h0, 4'h5, 4'h2, 4'h1};
      repeat (20) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      av(1'b0, 3'h6, 32'h0, r);
      chk("unmapped", 32'h0, r);
      // Wait count, delay, mux and tristate settings
      for (int i = 0; i < 4; i++) begin
         c = ctab[i];
         rdy_dly <= dtab[i];
         m = (c[3:0] > dtab[i]) ? c[3:0] : dtab[i];
         av(1'b1, 3'h0, {24'h0, c}, r);
         av(1'b1, 3'h1, 32'(i), r);
         av(1'b1, 3'h2, 32'ha5c0 + 32'(i), r);
         av(1'b1, 3'h3, 32'h1, r);
         av(1'b1, 3'h3, 32'h1, r);
         idle();
         chk("gap", 32'h1, 32'(gap >= 8 * (c[5] + c[6])));
         chk("lead", 32'(8 * (1 + c[4])), 32'(t_fall - t_ale));
         chk("low", 32'h1, 32'(t_rise - t_fall >= 8 * m));
         av(1'b1, 3'h3, 32'h0, r);
         idle();
         av(1'b0, 3'h5, 32'h0, r);
         chk("rdata", 32'ha5c0 + 32'(i), r);
         $display("bus cycle test %0d done", i);
      end
      // Hold during a running read, queued write while granted
      rdy_dly <= 4'h6;
      av(1'b1, 3'h0, 32'h0, r);
      av(1'b1, 3'h3, 32'h0, r);
      hold_req <= 1'b1;
      wt(1'b0, 1'b1);
      chk("cs pin", 32'h1, {31'h0, cs_level});
      chk("addr oe", 32'h0, {31'h0, i_ext_bus_if.addr_oe});
      av(1'b1, 3'h3, 32'h1, r);
      wt(1'b1, 1'b1);
      av(1'b0, 3'h4, 32'h0, r);
      chk("stalled", 32'h5, r & 32'h5);
      hold_req <= 1'b0;
      wt(1'b0, 1'b0);
      idle();
      $display("hold with regain request done");
      // Hold released without a regain request
      n0 = asked;
      hold_req <= 1'b1;
      wt(1'b0, 1'b1);
      hold_req <= 1'b0;
      wt(1'b0, 1'b0);
      chk("unasked", 32'(n0), 32'(asked));
      av(1'b1, 3'h3, 32'h0, r);
      idle();
      $display("unrequested release done");
      finish_test();
   end
   // Watchdog against a hung handshake
   initial begin
      #800000;
      fail_count++;
      finish_test();
   end
endmodule : ext_bus_ready_and_hold_arbitration_test
